// >>> common/quad_timer_pkg.sv
// Package for the four-channel 8/16-bit timer, capture and compare block.
// Assumes a single 100 MHz main clock and AXI4-Lite register access.
package quad_timer_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_MODE0     = 8'hD0;
    localparam logic [7:0] IDX_DATA0     = 8'hD1;
    localparam logic [7:0] IDX_MODE1     = 8'hD2;
    localparam logic [7:0] IDX_MATCH1    = 8'hD3;
    localparam logic [7:0] IDX_COUNT1    = 8'hD4;
    localparam logic [7:0] IDX_MODE2     = 8'hD6;
    localparam logic [7:0] IDX_DATA2     = 8'hD7;
    localparam logic [7:0] IDX_MODE3     = 8'hD8;
    localparam logic [7:0] IDX_MATCH3    = 8'hD9;
    localparam logic [7:0] IDX_COUNT3    = 8'hDA;
    localparam logic [7:0] IDX_WAVE_HIGH = 8'hDB;
    localparam logic [7:0] IDX_EDGE_SEL  = 8'hE0;
    localparam logic [7:0] IDX_PORT1_FN  = 8'hE1;
    localparam logic [7:0] IDX_FLAGS     = 8'hE2;

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int BIT_START      = 0;
    localparam int BIT_CONTINUE   = 1;
    localparam int BIT_CAP_LOWER  = 5;
    localparam int BIT_CAP_UPPER  = 4;
    localparam int BIT_WAVE_EN    = 5;
    localparam int BIT_PAIR_JOIN  = 6;
    localparam int BIT_ROUTE      = 0;
    localparam logic [2:0] SRC_EVENT = 3'h7;

    localparam logic [7:0] MATCH_RST  = 8'hFF;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;

    // ------------------------------------------------------------
    // Whole block state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0][7:0] mode;
        logic [3:0][7:0] match;
        logic [3:0][7:0] cnt;
        logic [3:0][7:0] cap;
        logic [11:0]     presc;
        logic [1:0]      ev_s1;
        logic [1:0]      ev_s2;
        logic [1:0]      ev_s3;
        logic [3:0]      ce_s1;
        logic [3:0]      ce_s2;
        logic [3:0]      ce_s3;
        logic [7:0]      edge_sel;
        logic            route;
        logic [7:0]      flags;
        logic            cmp;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [7:0]      rdata;
    } state_t;

    localparam state_t STATE_RST = '{match: {4{MATCH_RST}}, default: '0};

endpackage

// >>> logic/quad_timer.sv
// Four 8-bit timer/counters with pairing, capture and compare output.
// Assumes pins synchronous to mclk's domain only after the internal synchronisers.
//
// Overview of operation
// - 8-bit counter counts from zero, returns to zero after reaching match value.
// - Counter equal to match value sets that timer's match flag.
// - Timers 0 and 2 divide main clock by 2,4,8,32,128,512,2048.
// - Timers 1 and 3 divide main clock by 1, 2 or 8.
// - Event source counts once per rising edge on the event pin.
// - Only timers 0 and 2 have event pins; timers 1 and 3 count events only via the lower timer's clock.
// - Data address: writes set match value, reads return the counter, or the capture register in capture mode.
// - Joined pair counts 16 bits to combined match; only lower flag raised.
// - In capture mode counting and match flag behave as timer mode.
// - Selected capture edge copies count to capture register, then clears count.
// - Capture edge selectable as falling, rising or both.
// - Every selected capture edge also sets that pin's interrupt flag.
// - Reads return capture register in capture mode, else live counter.
// - 16-bit capture works as 8-bit capture on the joined pair.
// - Compare output mode sends each timer 2 match to the output pin while timer 3's BIT_WAVE_EN bit is clear.
// - Start or continue bit zero stops; start zero-to-one clears and restarts; one-to-one resumes.
// - Timer 0 source code 111 selects the event pin.
// - Compare pin toggles on each timer 2 match, giving an even square wave.
module quad_timer (
    input  wire logic        mclk,               // main clock, 100 MHz
    input  wire logic        reset,              // asynchronous reset, active high
    input  wire logic [11:0] s_axi_awaddr,       // write address
    input  wire logic        s_axi_awvalid,      // write address valid
    output logic             s_axi_awready,      // write address ready
    input  wire logic [31:0] s_axi_wdata,        // write data
    input  wire logic [3:0]  s_axi_wstrb,        // write byte strobes
    input  wire logic        s_axi_wvalid,       // write data valid
    output logic             s_axi_wready,       // write data ready
    output logic [1:0]       s_axi_bresp,        // write response
    output logic             s_axi_bvalid,       // write response valid
    input  wire logic        s_axi_bready,       // write response ready
    input  wire logic [11:0] s_axi_araddr,       // read address
    input  wire logic        s_axi_arvalid,      // read address valid
    output logic             s_axi_arready,      // read address ready
    output logic [31:0]      s_axi_rdata,        // read data
    output logic [1:0]       s_axi_rresp,        // read response
    output logic             s_axi_rvalid,       // read data valid
    input  wire logic        s_axi_rready,       // read data ready
    input  wire logic [1:0]  event_count_pin,    // event inputs of timers 0 and 2
    input  wire logic [3:0]  capture_edge_pin,   // capture edge inputs per timer
    output logic             compare_out_pin,    // compare output level
    output logic             compare_out_oe,     // compare output drive enable
    output logic [3:0]       match_irq_flag,     // sticky match flags
    output logic [3:0]       capture_irq_flag    // sticky capture-edge flags
);

    // ------------------------------------------------------------
    // State and derived terms
    // ------------------------------------------------------------
    quad_timer_pkg::state_t q_r;
    quad_timer_pkg::state_t q_nxt;

    logic [3:0] src_tick;
    logic [3:0] cedge;
    logic [3:0] capmode;
    logic [3:0] run;
    logic [3:0] adv_match;
    logic [1:0] ev_rise;
    logic [1:0] pair_on;
    logic       wr_go;
    logic       rd_go;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;

    function automatic logic div_tick(input logic [11:0] p, input int k);
        logic [11:0] mask;
        mask = 12'(({12'h000, 1'b1} << k) - 1);
        return (p & mask) == mask;
    endfunction

    assign ev_rise = q_r.ev_s2 & ~q_r.ev_s3;
    assign wr_go   = q_r.awready & s_axi_awvalid & s_axi_wvalid;
    assign rd_go   = q_r.arready & s_axi_arvalid;
    assign wr_idx  = s_axi_awaddr[9:2];
    assign rd_idx  = s_axi_araddr[9:2];

    // ------------------------------------------------------------
    // Per-timer clock source and capture edge
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_src
            logic rise_c;
            logic fall_c;
            assign rise_c = q_r.ce_s2[gi] & ~q_r.ce_s3[gi];
            assign fall_c = ~q_r.ce_s2[gi] & q_r.ce_s3[gi];
            always_comb begin
                unique case (q_r.edge_sel[2*gi+:2])
                    2'h0:    cedge[gi] = fall_c;
                    2'h1:    cedge[gi] = rise_c;
                    default: cedge[gi] = rise_c | fall_c;
                endcase
            end
            // run only with start and continue both set
            assign run[gi] = q_r.mode[gi][quad_timer_pkg::BIT_START]
                           & q_r.mode[gi][quad_timer_pkg::BIT_CONTINUE];
            if (gi % 2 == 0) begin : g_lower
                assign capmode[gi] = q_r.mode[gi][quad_timer_pkg::BIT_CAP_LOWER];
                always_comb begin
                    unique case (q_r.mode[gi][4:2])
                        3'h0:    src_tick[gi] = div_tick(q_r.presc, 1);
                        3'h1:    src_tick[gi] = div_tick(q_r.presc, 2);
                        3'h2:    src_tick[gi] = div_tick(q_r.presc, 3);
                        3'h3:    src_tick[gi] = div_tick(q_r.presc, 5);
                        3'h4:    src_tick[gi] = div_tick(q_r.presc, 7);
                        3'h5:    src_tick[gi] = div_tick(q_r.presc, 9);
                        3'h6:    src_tick[gi] = div_tick(q_r.presc, 11);
                        default: src_tick[gi] = ev_rise[gi/2];
                    endcase
                end
            end else begin : g_upper
                assign capmode[gi] = q_r.mode[gi][quad_timer_pkg::BIT_CAP_UPPER];
                assign pair_on[gi/2] = q_r.mode[gi][quad_timer_pkg::BIT_PAIR_JOIN];
                // fast taps, or the lower timer's clock
                always_comb begin
                    unique case (q_r.mode[gi][3:2])
                        2'h0:    src_tick[gi] = 1'b1;
                        2'h1:    src_tick[gi] = div_tick(q_r.presc, 1);
                        2'h2:    src_tick[gi] = div_tick(q_r.presc, 3);
                        default: src_tick[gi] = src_tick[gi-1];
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] c16;
        logic [7:0]  set_v;
        logic [7:0]  clr_v;
        logic        toggle;
        int          l;
        int          u;
        q_nxt     = q_r;
        c16       = '0;
        set_v     = '0;
        clr_v     = '0;
        toggle    = 1'b0;
        l         = 0;
        u         = 0;
        adv_match = '0;
        q_nxt.presc = q_r.presc + 12'h001;
        q_nxt.ev_s1 = event_count_pin;
        q_nxt.ev_s2 = q_r.ev_s1;
        q_nxt.ev_s3 = q_r.ev_s2;
        q_nxt.ce_s1 = capture_edge_pin;
        q_nxt.ce_s2 = q_r.ce_s1;
        q_nxt.ce_s3 = q_r.ce_s2;
        // every selected edge raises the pin flag
        set_v[7:4] = cedge;
        for (int p = 0; p < 2; p++) begin
            l = 2 * p;
            u = 2 * p + 1;
            if (pair_on[p]) begin
                // pair runs as one 16-bit counter on the lower clock
                c16 = {q_r.cnt[u], q_r.cnt[l]};
                if (run[l] && src_tick[l]) begin
                    if (c16 == {q_r.match[u], q_r.match[l]}) begin
                        c16          = '0;
                        set_v[l]     = 1'b1;
                        adv_match[l] = 1'b1;
                    end else begin
                        c16 = c16 + 16'h0001;
                    end
                end
                if (capmode[l] && cedge[l]) begin
                    q_nxt.cap[u] = q_r.cnt[u];
                    q_nxt.cap[l] = q_r.cnt[l];
                    c16          = '0;
                end
                q_nxt.cnt[u] = c16[15:8];
                q_nxt.cnt[l] = c16[7:0];
            end else begin
                for (int i = l; i <= u; i++) begin
                    // count, wrap and flag on match
                    if (run[i] && src_tick[i]) begin
                        if (q_r.cnt[i] == q_r.match[i]) begin
                            q_nxt.cnt[i] = '0;
                            set_v[i]     = 1'b1;
                            adv_match[i] = 1'b1;
                        end else begin
                            q_nxt.cnt[i] = q_r.cnt[i] + 8'h01;
                        end
                    end
                    if (capmode[i] && cedge[i]) begin
                        q_nxt.cap[i] = q_r.cnt[i];
                        q_nxt.cnt[i] = '0;
                    end
                end
            end
        end
        // timer 2 match toggles the compare pin when routed and timer 3's BIT_WAVE_EN bit is clear
        toggle = adv_match[2] & q_r.route & ~q_r.mode[3][quad_timer_pkg::BIT_WAVE_EN];
        if (toggle) begin
            q_nxt.cmp = ~q_r.cmp;
        end

        // Write channel: address and data are taken together.
        q_nxt.awready = s_axi_awvalid & s_axi_wvalid & ~q_r.awready & ~q_r.bvalid;
        q_nxt.wready  = s_axi_awvalid & s_axi_wvalid & ~q_r.awready & ~q_r.bvalid;
        if (q_r.bvalid && s_axi_bready) begin
            q_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp  = quad_timer_pkg::RESP_OKAY;
            if (s_axi_awaddr[11:10] != 2'h0) begin
                q_nxt.bresp = quad_timer_pkg::RESP_SLV;
            end else if (s_axi_wstrb[0]) begin
                unique case (wr_idx)
                    quad_timer_pkg::IDX_MODE0, quad_timer_pkg::IDX_MODE1,
                    quad_timer_pkg::IDX_MODE2, quad_timer_pkg::IDX_MODE3: begin
                        u = int'(wr_idx - quad_timer_pkg::IDX_MODE0) / 2;
                        u = (u > 1) ? u - 1 : u;
                        q_nxt.mode[u] = s_axi_wdata[7:0];
                        if (s_axi_wdata[quad_timer_pkg::BIT_START]
                            && !q_r.mode[u][quad_timer_pkg::BIT_START]) begin
                            q_nxt.cnt[u] = '0;
                        end
                    end
                    // data address writes the match value
                    quad_timer_pkg::IDX_DATA0:    q_nxt.match[0] = s_axi_wdata[7:0];
                    quad_timer_pkg::IDX_MATCH1:   q_nxt.match[1] = s_axi_wdata[7:0];
                    quad_timer_pkg::IDX_DATA2:    q_nxt.match[2] = s_axi_wdata[7:0];
                    quad_timer_pkg::IDX_MATCH3:   q_nxt.match[3] = s_axi_wdata[7:0];
                    quad_timer_pkg::IDX_EDGE_SEL: q_nxt.edge_sel = s_axi_wdata[7:0];
                    quad_timer_pkg::IDX_PORT1_FN:
                        q_nxt.route = s_axi_wdata[quad_timer_pkg::BIT_ROUTE];
                    quad_timer_pkg::IDX_FLAGS:    clr_v = s_axi_wdata[7:0];
                    quad_timer_pkg::IDX_COUNT1, quad_timer_pkg::IDX_COUNT3,
                    quad_timer_pkg::IDX_WAVE_HIGH: ;
                    default: q_nxt.bresp = quad_timer_pkg::RESP_SLV;
                endcase
            end
        end
        // A flag set in the same cycle as its clear stays set.
        q_nxt.flags = (q_r.flags & ~clr_v) | set_v;

        // Read channel.
        q_nxt.arready = s_axi_arvalid & ~q_r.arready & ~q_r.rvalid;
        if (q_r.rvalid && s_axi_rready) begin
            q_nxt.rvalid = 1'b0;
        end
        if (rd_go) begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rresp  = quad_timer_pkg::RESP_OKAY;
            q_nxt.rdata  = '0;
            l = pair_on[0] ? 0 : 1;
            u = pair_on[1] ? 2 : 3;
            if (s_axi_araddr[11:10] != 2'h0) begin
                q_nxt.rresp = quad_timer_pkg::RESP_SLV;
            end else begin
                unique case (rd_idx)
                    quad_timer_pkg::IDX_MODE0:    q_nxt.rdata = q_r.mode[0];
                    quad_timer_pkg::IDX_MODE1:    q_nxt.rdata = q_r.mode[1];
                    quad_timer_pkg::IDX_MODE2:    q_nxt.rdata = q_r.mode[2];
                    quad_timer_pkg::IDX_MODE3:    q_nxt.rdata = q_r.mode[3];
                    // shared address reads counter or capture
                    quad_timer_pkg::IDX_DATA0:
                        q_nxt.rdata = capmode[0] ? q_r.cap[0] : q_r.cnt[0];
                    quad_timer_pkg::IDX_COUNT1:
                        q_nxt.rdata = capmode[l] ? q_r.cap[1] : q_r.cnt[1];
                    quad_timer_pkg::IDX_DATA2:
                        q_nxt.rdata = capmode[2] ? q_r.cap[2] : q_r.cnt[2];
                    quad_timer_pkg::IDX_COUNT3:
                        q_nxt.rdata = capmode[u] ? q_r.cap[3] : q_r.cnt[3];
                    quad_timer_pkg::IDX_EDGE_SEL: q_nxt.rdata = q_r.edge_sel;
                    quad_timer_pkg::IDX_PORT1_FN: q_nxt.rdata = {7'h00, q_r.route};
                    quad_timer_pkg::IDX_FLAGS:    q_nxt.rdata = q_r.flags;
                    quad_timer_pkg::IDX_MATCH1, quad_timer_pkg::IDX_MATCH3,
                    quad_timer_pkg::IDX_WAVE_HIGH: ;
                    default: q_nxt.rresp = quad_timer_pkg::RESP_SLV;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q_r <= quad_timer_pkg::STATE_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign s_axi_awready    = q_r.awready;
    assign s_axi_wready     = q_r.wready;
    assign s_axi_bvalid     = q_r.bvalid;
    assign s_axi_bresp      = q_r.bresp;
    assign s_axi_arready    = q_r.arready;
    assign s_axi_rvalid     = q_r.rvalid;
    assign s_axi_rresp      = q_r.rresp;
    assign s_axi_rdata      = {24'h000000, q_r.rdata};
    assign compare_out_pin  = q_r.cmp;
    assign compare_out_oe   = q_r.route;
    assign match_irq_flag   = q_r.flags[3:0];
    assign capture_irq_flag = q_r.flags[7:4];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic quiet0;
    assign quiet0 = !wr_go && !cedge[0] && !pair_on[0];

    sequence s_t0_hits;
        quiet0 && run[0] && src_tick[0] && q_r.cnt[0] == q_r.match[0];
    endsequence
    sequence s_t2_toggle;
        adv_match[2] && q_r.route && !q_r.mode[3][quad_timer_pkg::BIT_WAVE_EN];
    endsequence

    wrap_to_zero_a: assert property (s_t0_hits |=> q_r.cnt[0] == 8'h00)
        else $error("timer 0 did not wrap to zero after match");
    match_flag_a: assert property (s_t0_hits |=> q_r.flags[0])
        else $error("timer 0 match did not set its flag");
    half_rate_a: assert property (q_r.mode[0][4:2] == 3'h0 && src_tick[0] |=> !src_tick[0])
        else $error("timer 0 divide by two ticked twice in a row");
    full_rate_a: assert property (q_r.mode[1][3:2] == 2'h0 |-> src_tick[1])
        else $error("timer 1 full-rate source missed a tick");
    event_only_a: assert property (
        q_r.mode[0][4:2] == quad_timer_pkg::SRC_EVENT && !ev_rise[0] |-> !src_tick[0])
        else $error("timer 0 ticked without an event edge");
    pair_flag_a: assert property (pair_on[0] && $past(pair_on[0]) |-> !$rose(q_r.flags[1]))
        else $error("upper timer flag raised while joined");
    capture_clear_a: assert property (
        capmode[0] && cedge[0] && !pair_on[0] && !wr_go
        |=> q_r.cnt[0] == 8'h00 && q_r.cap[0] == $past(q_r.cnt[0]))
        else $error("capture did not copy and clear the counter");
    edge_flag_a: assert property (cedge[3] |=> q_r.flags[7])
        else $error("capture edge did not set the pin flag");
    stop_hold_a: assert property (!run[0] && quiet0 |=> $stable(q_r.cnt[0]))
        else $error("stopped timer 0 changed its count");
    pin_toggle_a: assert property (s_t2_toggle |=> q_r.cmp != $past(q_r.cmp))
        else $error("compare pin failed to toggle on match");
    sync_delay_a: assert property (
        q_r.mode[0][4:2] == quad_timer_pkg::SRC_EVENT && $rose(event_count_pin[0])
        |-> !src_tick[0] ##1 !src_tick[0])
        else $error("event pin reached the counter without synchronising");

endmodule

// >>> test/pin_side_model.sv
// Pin-side model: event sources and capture-edge sources of the timer.
// Assumes the bench calls its tasks one at a time from one process.
module pin_side_model (
    input  wire logic       mclk,             // main clock
    output logic      [1:0] event_count_pin,  // event sources of timers 0 and 2
    output logic      [3:0] capture_edge_pin  // capture edge sources per timer
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        event_count_pin  = 2'h0;
        capture_edge_pin = 4'h0;
    end
    // one clean pulse.
    // Each level is held three clocks so the synchroniser cannot miss it.
    task automatic pulse(input int k);
        @(posedge mclk) event_count_pin[k] <= 1'b1;
        repeat (3) @(posedge mclk);
        event_count_pin[k] <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic edge_to(input int i, input logic v);
        @(posedge mclk) capture_edge_pin[i] <= v;
        repeat (4) @(posedge mclk);
    endtask
endmodule

// >>> test/test_quad_timer.sv
// Bench for the four-channel timer: bus master, pin model, count model.
// Assumes one 100 MHz clock and an asynchronous active-high reset.
module test_quad_timer;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, reset, awv, wv, bvalid, bready, arv, rvalid, rready;
    logic        awready, wready, arready, cmp_pin, cmp_oe, mp, jn;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, mirq, cirq, capp, mf, cf;
    logic [1:0]  bresp, rresp, evp;
    int          error_cnt, samples_checked, seed, cap0, n, m, mc[4], mm[4];
    quad_timer quad_timer_inst (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .event_count_pin(evp), .capture_edge_pin(capp),
        .compare_out_pin(cmp_pin), .compare_out_oe(cmp_oe),
        .match_irq_flag(mirq), .capture_irq_flag(cirq));
    pin_side_model pin_side_model_inst (.mclk(mclk), .event_count_pin(evp),
        .capture_edge_pin(capp));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Ready outputs are registered, so they are looked at mid-cycle.
    task automatic wt(ref logic s);
        int k;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (s !== 1'b1 && k < 300);
        if (k >= 300) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge mclk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata  <= {24'h0, d};
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        wt(awready);
        @(posedge mclk);
        awv <= 1'b0;
        wv  <= 1'b0;
        wt(bvalid);
        chk("bresp", 32'h0, {30'h0, bresp});
        @(posedge mclk);
        bready <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
        @(posedge mclk);
        araddr <= {2'h0, idx, 2'h0};
        arv    <= 1'b1;
        rready <= 1'b1;
        wt(arready);
        @(posedge mclk);
        arv <= 1'b0;
        wt(rvalid);
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, rresp);
        @(posedge mclk);
        rready <= 1'b0;
    endtask
    // Pulses event pin of timer t and advances the count model.
    task automatic ev(input int t, input int k);
        int v;
        repeat (k) begin
            pin_side_model_inst.pulse(t / 2);
            v = mc[1] * 256 + mc[0] + 1;
            if (jn && t == 0) begin
                if (v == mm[1] * 256 + mm[0] + 1) v = 0;
                if (v == 0) mf[0] = 1'b1;
                mc[0] = v % 256;
                mc[1] = v / 256;
            end else if (mc[t] == mm[t]) begin
                mc[t] = 0;
                mf[t] = 1'b1;
                if (t == 2) mp = ~mp;
            end else mc[t]++;
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {awv, wv, bready, arv, rready, mp, jn} = '0;
        {mf, cf, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        seed = 80;
        reset = 1'b1;
        mm = '{default: 255};
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rdc(8'hD1, 32'h0, 2'h0);
        rdc(8'hD4, 32'h0, 2'h0);
        rdc(8'hC0, 32'h0, 2'h2);
        m = 4 + $unsigned($random(seed)) % 6;
        n = 1 + $unsigned($random(seed)) % (m - 1);
        wr(8'hD1, m[7:0]);
        mm[0] = m;
        wr(8'hD0, 8'h1F);
        ev(0, n);
        rdc(8'hD1, mc[0], 2'h0);
        ev(0, m + 1 - n);
        rdc(8'hD1, mc[0], 2'h0);
        chk("match flags", mf, mirq);
        wr(8'hD0, 8'h1E);
        pin_side_model_inst.pulse(0);
        rdc(8'hD1, mc[0], 2'h0);
        wr(8'hD0, 8'h1F);
        mc[0] = 0;
        ev(0, 2);
        wr(8'hD0, 8'h1F);
        rdc(8'hD1, mc[0], 2'h0);
        wr(8'hD0, 8'h1D);
        pin_side_model_inst.pulse(0);
        rdc(8'hD1, mc[0], 2'h0);
        wr(8'hD0, 8'h3F);
        for (int e = 0; e < 3; e++) begin
            wr(8'hE0, e[7:0]);
            ev(0, 1);
            pin_side_model_inst.edge_to(0, 1'b1);
            if (e != 0) {cap0, mc[0], cf[0]} = {mc[0], 32'h0, 1'b1};
            rdc(8'hD1, cap0, 2'h0);
            pin_side_model_inst.edge_to(0, 1'b0);
            if (e != 1) {cap0, mc[0], cf[0]} = {mc[0], 32'h0, 1'b1};
            rdc(8'hD1, cap0, 2'h0);
            chk("capture flags", cf, cirq);
        end
        wr(8'hD0, 8'h1F);
        rdc(8'hD1, mc[0], 2'h0);
        wr(8'hE1, 8'h01);
        chk("compare oe", 32'h1, cmp_oe);
        wr(8'hD7, 8'h01);
        mm[2] = 1;
        wr(8'hD6, 8'h1F);
        for (int i = 0; i < 3; i++) begin
            ev(2, 2);
            chk("compare pin", mp, cmp_pin);
        end
        wr(8'hD0, 8'h1C);
        wr(8'hD1, 8'h01);
        wr(8'hD3, 8'h01);
        wr(8'hD2, 8'h4C);
        wr(8'hD0, 8'h1F);
        wr(8'hE2, 8'hFF);
        {mf, cf, jn, mc[0], mc[1], mm[0], mm[1]} = {9'h1, 32'h0, 32'h0, 32'h1, 32'h1};
        ev(0, 257);
        rdc(8'hD1, mc[0], 2'h0);
        rdc(8'hD4, mc[1], 2'h0);
        ev(0, 1);
        chk("match flags", mf, mirq);
        rdc(8'hD4, mc[1], 2'h0);
        tally_and_finish();
    end
endmodule
